//--- logic/sacc_pkg.sv
// Package: register map, field layout and timing constants of the converter control block
package sacc_pkg;
   // APB byte addresses
   localparam logic [7:0] SACC_CTRL_ADDR = 8'h00;
   localparam logic [7:0] SACC_RESULT_ADDR = 8'h04;
   localparam logic [7:0] SACC_IRQ_ADDR = 8'h08;
   localparam logic [7:0] SACC_STATUS_ADDR = 8'h0c;
   localparam logic [7:0] SACC_MASK_ADDR = 8'h10;
   // Control word bit positions
   localparam int SACC_EN_BIT = 7;
   localparam int SACC_SPD_HI_BIT = 6;
   localparam int SACC_SPD_LO_BIT = 5;
   localparam int SACC_DONE_BIT = 4;
   localparam int SACC_START_BIT = 3;
   localparam int SACC_CH_HI_BIT = 2;
   // Interrupt enable word bit positions
   localparam int SACC_IE_CONV_BIT = 0;
   localparam int SACC_IE_SHARED_BIT = 1;
   localparam int SACC_IE_GLOBAL_BIT = 2;
   // Reset values
   localparam logic [7:0] SACC_CTRL_RST = 8'h00;
   localparam logic [7:0] SACC_RESULT_RST = 8'h00;
   localparam logic [2:0] SACC_IE_RST = 3'h0;
   localparam logic [1:0] SACC_EVT_RST = 2'h0;
   // Divider ratios for speed codes 00..11
   localparam logic [10:0] SACC_DIV_0 = 11'd1080;
   localparam logic [10:0] SACC_DIV_1 = 11'd810;
   localparam logic [10:0] SACC_DIV_2 = 11'd540;
   localparam logic [10:0] SACC_DIV_3 = 11'd270;
   // One conversion: one sample tick plus one tick per result bit
   localparam int SACC_RES_BITS = 8;
   localparam logic [3:0] SACC_CONV_TICKS = 4'd9;
   // Status events: bit 0 done, bit 1 start refused
   localparam int SACC_EVT_DONE = 0;
   localparam int SACC_EVT_REFUSED = 1;

   typedef enum logic [1:0] {SACC_OFF, SACC_IDLE, SACC_CONV} sacc_state_e;

   typedef struct packed {
      logic [2:0] channel;
      logic sample;
      logic [7:0] trial;
   } sacc_ana_s;

   typedef struct packed {
      sacc_state_e state;
      logic en;
      logic [1:0] speed;
      logic done;
      logic start;
      logic [2:0] chan;
      logic [7:0] result;
      logic [7:0] sar;
      logic [3:0] step;
      logic [10:0] div_cnt;
      logic [2:0] ie;
      logic [1:0] evt;
      logic [1:0] evt_mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic ana_on;
      sacc_ana_s ana;
   } sacc_state_s;
endpackage : sacc_pkg

//--- logic/sacc_top.sv
// Converter control block: APB registers, clock divider and successive approximation sequencer
//Contract
// - Converter runs only while enable is one; otherwise held in shutdown.
// - Result is eight bits found by successive approximation, up to 100 ksps.
// - Conversion clock is system clock divided by ratio from speed bits.
// - Channel bits route chosen port-1 pin to the input selector, single-ended.
// - Setting start begins a conversion whose length follows the speed setting.
// - At the end, clear start, set done and load result in one cycle.
// - Completed result is readable from the result register once done is high.
// - Interrupt only when converter, shared and global enables are all set; the code also raises it for any status event whose mask bit is set.
// - No conversions while the chip is in power-down.
// - Speed codes 00..11 divide by 1080, 810, 540 and 270.
// - Channel code n selects analog input n on port-1 pin n.
// - Software cannot clear start; no new start while start or done is high.
`timescale 1ns/1ps
module sacc_top
   import sacc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Chip power state
   input wire logic power_down,
   // Analog side: comparator says input is at or above trial level
   input wire logic comp_high,
   output logic converter_on,
   output logic sample_hold,
   output logic [2:0] analog_input_selector,
   output logic [7:0] trial_code,
   // Interrupt
   output logic irq
);
   sacc_state_s st_reg;
   sacc_state_s st_next;

   function automatic logic [10:0] sacc_span(input logic [1:0] code);
      case (code)
         2'h0: sacc_span = SACC_DIV_0;
         2'h1: sacc_span = SACC_DIV_1;
         2'h2: sacc_span = SACC_DIV_2;
         default: sacc_span = SACC_DIV_3;
      endcase
   endfunction : sacc_span

   // Whole conversion lasts the chosen ratio, so one tick is a ninth of it
   function automatic logic [10:0] sacc_ratio(input logic [1:0] code);
      sacc_ratio = sacc_span(code) / {7'h0, SACC_CONV_TICKS};
   endfunction : sacc_ratio

   function automatic logic [7:0] sacc_ctrl_word(input sacc_state_s s);
      sacc_ctrl_word = {s.en, s.speed, s.done, s.start, s.chan};
   endfunction : sacc_ctrl_word

   logic acc;
   logic wr;
   logic conv_tick;
   logic start_req;
   logic done_set;
   logic refused;
   logic [7:0] wbyte;
   logic [7:0] sar_kept;

   always_comb begin
      st_next = st_reg;
      acc = psel && penable;
      wr = acc && pwrite;
      wbyte = pwdata[7:0];
      done_set = 1'b0;
      refused = 1'b0;
      sar_kept = st_reg.sar;
      // Divider runs only during a conversion so each one starts phase-aligned
      conv_tick = (st_reg.state == SACC_CONV) && (st_reg.div_cnt == 11'd1);
      start_req = wr && (paddr == SACC_CTRL_ADDR) && wbyte[SACC_START_BIT] && !st_reg.start;

      // Register writes
      if (wr && paddr == SACC_CTRL_ADDR) begin
         st_next.en = wbyte[SACC_EN_BIT];
         st_next.speed = wbyte[SACC_SPD_HI_BIT:SACC_SPD_LO_BIT];
         st_next.chan = wbyte[SACC_CH_HI_BIT:0];
         // Done flag: software may clear or set it, like any writable bit
         st_next.done = wbyte[SACC_DONE_BIT];
      end
      if (wr && paddr == SACC_IRQ_ADDR) begin
         st_next.ie = wbyte[2:0];
      end
      if (wr && paddr == SACC_MASK_ADDR) begin
         st_next.evt_mask = wbyte[1:0];
      end
      if (wr && paddr == SACC_STATUS_ADDR) begin
         st_next.evt = st_reg.evt & ~wbyte[1:0];
      end

      // Start only from idle with start and done both low and enable set
      if (start_req) begin
         if (st_reg.state == SACC_IDLE && !st_reg.done && !power_down
             && wbyte[SACC_EN_BIT]) begin
            st_next.start = 1'b1;
            st_next.state = SACC_CONV;
            st_next.div_cnt = sacc_ratio(st_next.speed);
            st_next.step = 4'd0;
            st_next.sar = 8'h80;
            st_next.ana.channel = st_next.chan;
            st_next.ana.sample = 1'b1;
         end else begin
            refused = 1'b1;
         end
      end

      case (st_reg.state)
         SACC_OFF: begin
            if (st_next.en && !power_down) begin
               st_next.state = SACC_IDLE;
            end
         end
         SACC_IDLE: begin
            if (!st_next.en || power_down) begin
               st_next.state = SACC_OFF;
            end
         end
         SACC_CONV: begin
            if (!st_next.en || power_down) begin
               // Abort: start drops, result untouched, no done
               st_next.state = SACC_OFF;
               st_next.start = 1'b0;
               st_next.ana.sample = 1'b0;
            end else if (conv_tick) begin
               st_next.div_cnt = sacc_ratio(st_reg.speed);
               st_next.step = st_reg.step + 4'd1;
               if (st_reg.step == 4'd0) begin
                  st_next.ana.sample = 1'b0;
               end else begin
                  // Keep or drop trial bit, then try the next lower bit
                  sar_kept = comp_high ? st_reg.sar : (st_reg.sar & ~st_reg.ana.trial);
                  st_next.sar = sar_kept | (st_reg.ana.trial >> 1);
               end
               if (st_reg.step == SACC_CONV_TICKS - 4'd1) begin
                  st_next.state = SACC_IDLE;
                  st_next.start = 1'b0;
                  st_next.result = sar_kept;
                  done_set = 1'b1;
               end
            end else begin
               st_next.div_cnt = st_reg.div_cnt - 11'd1;
            end
         end
         default: st_next.state = SACC_OFF;
      endcase

      // Trial bit marker: the single bit now under test
      if (st_next.state == SACC_CONV && st_next.step != 4'd0) begin
         st_next.ana.trial = 8'h80 >> (st_next.step - 4'd1);
      end else begin
         st_next.ana.trial = 8'h80;
      end

      // Hardware set wins over a software clear in the same cycle
      if (done_set) begin
         st_next.done = 1'b1;
         st_next.evt[SACC_EVT_DONE] = 1'b1;
      end
      if (refused) begin
         st_next.evt[SACC_EVT_REFUSED] = 1'b1;
      end

      st_next.ana_on = (st_next.state != SACC_OFF);
      st_next.irq = (st_next.done && (&st_next.ie))
                    || |(st_next.evt & st_next.evt_mask);

      // APB answer: zero wait states, unmapped addresses flag an error
      st_next.pready = 1'b1;
      st_next.pslverr = 1'b0;
      st_next.prdata = 32'h0;
      if (psel && !penable) begin
         case (paddr)
            SACC_CTRL_ADDR: st_next.prdata = {24'h0, sacc_ctrl_word(st_reg)};
            SACC_RESULT_ADDR: st_next.prdata = {24'h0, st_reg.result};
            SACC_IRQ_ADDR: st_next.prdata = {29'h0, st_reg.ie};
            SACC_STATUS_ADDR: st_next.prdata = {30'h0, st_reg.evt};
            SACC_MASK_ADDR: st_next.prdata = {30'h0, st_reg.evt_mask};
            default: st_next.pslverr = 1'b1;
         endcase
         // Read data reflects state at setup; a same-cycle completion shows next read
      end else if (acc) begin
         st_next.prdata = st_reg.prdata;
         st_next.pslverr = st_reg.pslverr;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg.state <= SACC_OFF;
         st_reg.en <= SACC_CTRL_RST[SACC_EN_BIT];
         st_reg.speed <= SACC_CTRL_RST[SACC_SPD_HI_BIT:SACC_SPD_LO_BIT];
         st_reg.done <= SACC_CTRL_RST[SACC_DONE_BIT];
         st_reg.start <= SACC_CTRL_RST[SACC_START_BIT];
         st_reg.chan <= SACC_CTRL_RST[SACC_CH_HI_BIT:0];
         st_reg.result <= SACC_RESULT_RST;
         st_reg.sar <= 8'h00;
         st_reg.step <= 4'd0;
         st_reg.div_cnt <= 11'd0;
         st_reg.ie <= SACC_IE_RST;
         st_reg.evt <= SACC_EVT_RST;
         st_reg.evt_mask <= SACC_EVT_RST;
         st_reg.prdata <= 32'h0;
         st_reg.pready <= 1'b1;
         st_reg.pslverr <= 1'b0;
         st_reg.irq <= 1'b0;
         st_reg.ana_on <= 1'b0;
         st_reg.ana <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign irq = st_reg.irq;
   assign converter_on = st_reg.ana_on;
   assign sample_hold = st_reg.ana.sample;
   assign analog_input_selector = st_reg.ana.channel;
   assign trial_code = st_reg.sar;

   // Checks
   // Age of the running conversion in cycles; back to zero one cycle after a conversion ends
   localparam int CONV_MAX = 1081;
   logic [13:0] conv_age;
   logic ctrl_wr;
   logic keep_on;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_age <= 14'd0;
      end else if (st_reg.state == SACC_CONV) begin
         conv_age <= conv_age + 14'd1;
      end else begin
         conv_age <= 14'd0;
      end
   end

   // Control writes seen on the bus, and whether the converter stays powered
   assign ctrl_wr = psel && penable && pwrite && (paddr == SACC_CTRL_ADDR);
   assign keep_on = !power_down && !(ctrl_wr && !pwdata[SACC_EN_BIT]);

   // Enable and power state are registered together, so a cleared enable shows as off in the same cycle
   off_shutdown_a: assert property (@(posedge clk) disable iff (!rst_b)
      !st_reg.en |-> !converter_on)
      else $error("converter on while disabled");

   conv_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
      conv_age < CONV_MAX[13:0])
      else $error("conversion too long");

   div_reload_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.state == SACC_CONV && conv_tick && st_next.state == SACC_CONV)
      |=> st_reg.div_cnt == sacc_ratio(st_reg.speed))
      else $error("divider reload wrong");

   end_same_a: assert property (@(posedge clk) disable iff (!rst_b)
      ($fell(st_reg.start) && st_reg.en && !power_down) |-> st_reg.done)
      else $error("start cleared without done");

   result_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      !$rose(st_reg.done) && !$past(st_reg.done == 1'b0 && st_next.done)
      |-> $stable(st_reg.result) or $rose(st_reg.done))
      else $error("result changed without completion");

   irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.done && (&st_reg.ie)) |-> irq)
      else $error("interrupt missing");

   no_restart_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.done && st_reg.state != SACC_CONV) |=> st_reg.state != SACC_CONV)
      else $error("conversion began with done high");

   pd_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
      power_down |=> st_reg.state != SACC_CONV)
      else $error("conversion during power-down");

   start_conv_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ctrl_wr && pwdata[SACC_START_BIT] && pwdata[SACC_EN_BIT] && !power_down
       && st_reg.state == SACC_IDLE && !st_reg.start && !st_reg.done)
      |=> (st_reg.start && sample_hold && trial_code == 8'h80
           && analog_input_selector == $past(pwdata[SACC_CH_HI_BIT:0])))
      else $error("start did not begin a conversion");

   start_kept_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.state == SACC_CONV && !conv_tick && keep_on) |=> st_reg.start)
      else $error("start dropped during a conversion");

   // A software clear of done in the completing cycle must lose
   done_same_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.state == SACC_CONV && conv_tick && st_reg.step == SACC_CONV_TICKS - 4'd1
       && keep_on)
      |=> (st_reg.done && !st_reg.start && st_reg.evt[SACC_EVT_DONE]
           && st_reg.result == trial_code))
      else $error("completion not in one cycle");

   conv_span_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.state == SACC_CONV && st_next.state == SACC_IDLE)
      |-> conv_age == {3'h0, sacc_span(st_reg.speed)} - 14'd1)
      else $error("conversion length wrong");

   sample_len_a: assert property (@(posedge clk) disable iff (!rst_b)
      ($fell(sample_hold) && st_reg.state == SACC_CONV)
      |-> conv_age == {3'h0, sacc_span(st_reg.speed)} / {10'h0, SACC_CONV_TICKS})
      else $error("sample period wrong");

   start_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ctrl_wr && pwdata[SACC_START_BIT] && !pwdata[SACC_EN_BIT]) |=> st_reg.state != SACC_CONV)
      else $error("conversion began while disabled");

   conv_power_a: assert property (@(posedge clk) disable iff (!rst_b)
      st_reg.state == SACC_CONV |-> converter_on)
      else $error("conversion with converter off");

   result_read_a: assert property (@(posedge clk) disable iff (!rst_b)
      (psel && !penable && paddr == SACC_RESULT_ADDR)
      |=> prdata == {24'h0, $past(st_reg.result)})
      else $error("result read wrong");

   sel_steady_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_reg.state == SACC_CONV && $past(st_reg.state) == SACC_CONV)
      |-> $stable(analog_input_selector))
      else $error("selector moved during a conversion");

   irq_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!(st_reg.done && (&st_reg.ie)) && !(|(st_reg.evt & st_reg.evt_mask))) |-> !irq)
      else $error("interrupt without cause");
endmodule : sacc_top

//--- test/sacc_ana_model.sv
// Behavioural analog selector and comparator facing the converter control block
`timescale 1ns/1ps
module sacc_ana_model (
   // Clock
   input wire logic clk,
   // Control from the block
   input wire logic converter_on,
   input wire logic sample_hold,
   input wire logic [2:0] analog_input_selector,
   input wire logic [7:0] trial_code,
   // Eight channel levels, eight bits each; pins only sensed, never driven
   input wire logic [63:0] levels,
   // Comparator
   output logic comp_high
);
   logic [7:0] held = 8'h00;
   logic toggle = 1'b0;
   always @(posedge clk) begin
      toggle <= ~toggle;
      if (sample_hold) held <= levels[analog_input_selector*8 +: 8];
   end
   // Unpowered comparator output is meaningless, so it wanders instead of holding
   assign comp_high = converter_on ? (held >= trial_code) : toggle;
endmodule : sacc_ana_model

//--- test/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
   import sacc_pkg::*;
   typedef struct {logic [32:0] v; logic [32:0] m; string n;} sacc_note_s;
   localparam logic [32:0] ALL = {33{1'b1}};
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic power_down = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, comp_high, converter_on, sample_hold, irq;
   logic [2:0] sel, c;
   logic [1:0] s;
   logic [10:0] nd;
   logic [7:0] trial_code;
   logic [63:0] levels;
   sacc_note_s notes[$];
   int miscompares = 0, checked = 0, cyc = 0, t0, seed = 32'h08a9;
   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   sacc_top uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_down(power_down), .comp_high(comp_high), .converter_on(converter_on),
      .sample_hold(sample_hold), .analog_input_selector(sel), .trial_code(trial_code),
      .irq(irq));
   sacc_ana_model ana (.clk(clk), .converter_on(converter_on), .sample_hold(sample_hold),
      .analog_input_selector(sel), .trial_code(trial_code), .levels(levels),
      .comp_high(comp_high));
   task automatic check(string n, logic [32:0] seen, logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(logic [7:0] a, logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic rd(logic [7:0] a, logic [32:0] e, logic [32:0] m, string n);
      notes.push_back('{e, m, n});
      apb(1'b0, a, 32'h0);
   endtask : rd
   function automatic logic [7:0] ctl(logic [1:0] sp, logic dn, logic st, logic [2:0] ch);
      return {1'b1, sp, dn, st, ch};
   endfunction : ctl
   // Read results are judged when the access completes, oldest note first
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite && notes.size() > 0) begin
         check(notes[0].n, {pslverr, prdata} & notes[0].m, notes[0].v);
         void'(notes.pop_front());
      end
   end
   initial begin
      #(100 * 95000);
      miscompares++;
      stop_test();
   end
   initial begin
      for (int i = 0; i < 8; i++) levels[i*8 +: 8] = $random(seed);
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      rd(SACC_CTRL_ADDR, {25'h0, SACC_CTRL_RST}, ALL, "ctrl");
      rd(SACC_RESULT_ADDR, {25'h0, SACC_RESULT_RST}, ALL, "result");
      rd(8'h14, 33'h1_0000_0000, 33'h1_0000_0000, "unmapped");
      wr(SACC_CTRL_ADDR, 8'h08);
      rd(SACC_CTRL_ADDR, 33'h0, ALL, "ctrl off start");
      rd(SACC_STATUS_ADDR, 33'h2, ALL, "refused");
      #1 check("converter_on", converter_on, 1'b0);
      wr(SACC_STATUS_ADDR, 8'h03);
      wr(SACC_CTRL_ADDR, 8'h80);
      repeat (50) @(posedge clk);
      wr(SACC_CTRL_ADDR, 8'h90);
      for (int i = 0; i < 8; i++) begin
         wr(SACC_IRQ_ADDR, i[7:0]);
         @(posedge clk);
         #1 check("irq enables", irq, i == 7);
      end
      wr(SACC_IRQ_ADDR, 8'h00);
      wr(SACC_MASK_ADDR, 8'h01);
      for (int i = 0; i < 8; i++) begin
         s = i % 4;
         c = i;
         nd = (s == 0) ? SACC_DIV_0 : (s == 1) ? SACC_DIV_1 : (s == 2) ? SACC_DIV_2 : SACC_DIV_3;
         wr(SACC_CTRL_ADDR, ctl(s, 0, 0, c));
         wr(SACC_CTRL_ADDR, ctl(s, 0, 1, c));
         #1 t0 = cyc;
         check("sample_hold", sample_hold, 1'b1);
         check("selector", sel, c);
         check("converter_on", converter_on, 1'b1);
         wr(SACC_CTRL_ADDR, ctl(s, 0, 0, c));
         rd(SACC_CTRL_ADDR, ctl(s, 0, 1, c), ALL, "start held");
         while (irq !== 1'b1 && cyc - t0 < 12000) begin
            @(posedge clk);
            #1;
         end
         check("conv time", cyc - t0, nd);
         rd(SACC_CTRL_ADDR, ctl(s, 1, 0, c), ALL, "ctrl done");
         rd(SACC_RESULT_ADDR, levels[c*8 +: 8], ALL, "result");
         wr(SACC_CTRL_ADDR, ctl(s, 1, 1, c));
         rd(SACC_CTRL_ADDR, ctl(s, 1, 0, c), ALL, "start refused");
         rd(SACC_STATUS_ADDR, 33'h3, ALL, "status");
         wr(SACC_STATUS_ADDR, 8'h03);
         wr(SACC_CTRL_ADDR, ctl(s, 0, 0, c));
         #1 check("irq cleared", irq, 1'b0);
      end
      wr(SACC_CTRL_ADDR, ctl(2'h3, 0, 1, 3'h7));
      repeat (100) @(posedge clk);
      power_down <= 1'b1;
      repeat (2) @(posedge clk);
      rd(SACC_CTRL_ADDR, ctl(2'h3, 0, 0, 3'h7), ALL, "aborted");
      rd(SACC_RESULT_ADDR, levels[63:56], ALL, "result kept");
      power_down <= 1'b0;
      wr(SACC_CTRL_ADDR, 8'h00);
      @(posedge clk);
      #1 check("converter_on", converter_on, 1'b0);
      stop_test();
   end
endmodule : tb_top
